// >>> design/upe_addr.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_regs.svh"
module upe_addr (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wr,
  input wire logic [7:0] i_data,
  input wire logic i_other_cmd,
  input wire logic i_status_done,
  input wire logic i_bus_reset,
  output logic [6:0] o_function_address,
  output logic o_function_enable
);
  import upe_pkg::*;
  upe_addr_s q;
  upe_addr_s next_q;

  always_comb begin
    next_q = q;
    if (i_other_cmd) begin
      next_q.back2back = 1'b0;
    end
    if (i_status_done && q.pend_valid) begin
      next_q.addr = q.pend_addr;
      next_q.enable = q.pend_en;
      next_q.pend_valid = 1'b0;
    end
    if (i_wr) begin
      next_q.pend_addr = i_data[6:0];
      next_q.pend_en = i_data[`UPE_ADDR_EN_BIT];
      next_q.back2back = 1'b1;
      if (q.back2back && q.pend_valid && q.pend_addr == i_data[6:0]) begin
        next_q.addr = i_data[6:0];
        next_q.enable = i_data[`UPE_ADDR_EN_BIT];
        next_q.pend_valid = 1'b0;
      end else begin
        next_q.pend_valid = 1'b1;
      end
    end
    if (i_bus_reset) begin
      next_q.addr = `UPE_ADDR_RESET;
      next_q.enable = 1'b1;
      next_q.pend_valid = 1'b0;
      next_q.back2back = 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_function_address = q.addr;
  assign o_function_enable = q.enable;
endmodule
`default_nettype wire

// >>> design/upe_cmd.sv
`timescale 1ns/1ps
`default_nettype none
`include "upe_regs.svh"
// Behaviour
// - Codes 40h+ep select endpoint, read clears interrupt
// - Same code with write phase sets endpoint status
// - Clear buffer optional read; validate has none
// - Address byte: bits 6:0 address, bit 7 enable
// - Address applies after status stage, or twice
// - Power-on clears enable; bus reset: address 0, enabled
// - After bus reset answer address 0, endpoint 0
// - Configure bit 0; configured enables non-control endpoints
// - Control endpoints always answer traffic
// - Mode bits 6,5: bulk OUT/IN NAK interrupts
// - Mode bits 4,3: interrupt OUT/IN NAK interrupts
// - Mode bits 2,1: control OUT/IN NAK interrupts
// - Mode bit 0 holds clock request high
// - Frame number from last received start-of-frame
// - Frame number low byte first, high optional
// - Missing start-of-frame keeps previous frame number
// - CRC-damaged frame number stored as received
// - Words written to code register, results in data
// - Word-taken and result-ready flags, cleared by software
module upe_cmd (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_wr,
  input wire logic [31:0] i_cmd_code,
  input wire logic [7:0] i_flag_clr,
  input wire logic i_bus_reset,
  input wire logic i_status_done,
  input wire logic i_sof_valid,
  input wire logic [10:0] i_sof_frame,
  input wire logic [7:0] i_ep_status,
  input wire logic [7:0] i_clr_buf_status,
  input wire logic [31:0] i_ep_enabled,
  input wire logic i_needclk_req,
  output logic [7:0] o_cmd_data,
  output logic o_cmd_word_taken_flag,
  output logic o_cmd_result_ready_flag,
  output logic [6:0] o_function_address,
  output logic o_function_enable,
  output logic o_configured_flag,
  output logic [31:0] o_ep_respond,
  output logic o_nak_irq_bulk_out,
  output logic o_nak_irq_bulk_in,
  output logic o_nak_irq_intr_out,
  output logic o_nak_irq_intr_in,
  output logic o_nak_irq_ctrl_out,
  output logic o_nak_irq_ctrl_in,
  output logic o_keep_clock_running,
  output logic o_usb_needclk,
  output logic [4:0] o_sel_ep,
  output logic o_ep_irq_clr,
  output logic o_ep_status_wr,
  output logic [7:0] o_ep_status_data,
  output logic o_clr_buf,
  output logic o_valid_buf,
  output logic [10:0] o_frame_number
);
  import upe_pkg::*;

  upe_cmd_s q;
  upe_cmd_s next_q;
  logic addr_wr;
  logic other_cmd;
  logic [10:0] frame_num;
  logic [7:0] ph;
  logic [7:0] cb;
  localparam logic [31:0] ctrl_ep_mask = `UPE_CTRL_EP_MASK;

  // Per-endpoint code range test
  function automatic logic in_ep_range(input logic [7:0] code, input logic [7:0] base);
    in_ep_range = (code >= base) && (code < base + `UPE_CODE_EP_SPAN);
  endfunction

  function automatic logic known_code(input logic [7:0] code);
    known_code = in_ep_range(code, `UPE_CODE_SEL_EP) ||
                 in_ep_range(code, `UPE_CODE_SEL_CLR) ||
                 code == `UPE_CODE_SET_ADDR || code == `UPE_CODE_CONFIG ||
                 code == `UPE_CODE_SET_MODE || code == `UPE_CODE_RD_FRAME ||
                 code == `UPE_CODE_CLR_BUF || code == `UPE_CODE_VAL_BUF;
  endfunction

  assign ph = i_cmd_code[15:8];
  assign cb = i_cmd_code[23:16];

  upe_addr u_addr (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_wr(addr_wr),
    .i_data(cb),
    .i_other_cmd(other_cmd),
    .i_status_done(i_status_done),
    .i_bus_reset(i_bus_reset),
    .o_function_address(o_function_address),
    .o_function_enable(o_function_enable)
  );

  upe_frame u_frame (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_sof_valid(i_sof_valid),
    .i_sof_frame(i_sof_frame),
    .o_frame_number(frame_num)
  );

  always_comb begin
    next_q = q;
    addr_wr = 1'b0;
    other_cmd = 1'b0;
    next_q.ep_irq_clr = 1'b0;
    next_q.ep_status_wr = 1'b0;
    next_q.clr_buf = 1'b0;
    next_q.valid_buf = 1'b0;
    // Clears first so that a same-cycle set wins
    if (i_flag_clr[`UPE_FLAG_TAKEN_BIT]) begin
      next_q.taken = 1'b0;
    end
    if (i_flag_clr[`UPE_FLAG_READY_BIT]) begin
      next_q.ready = 1'b0;
    end
    if (i_cmd_wr) begin
      case (ph)
        `UPE_PH_CMD: begin
          if (known_code(cb)) begin
            next_q.taken = 1'b1;
            next_q.code = cb;
            next_q.frame_hi = 1'b0;
            if (cb != `UPE_CODE_SET_ADDR) begin
              other_cmd = 1'b1;
            end
            if (in_ep_range(cb, `UPE_CODE_SEL_CLR)) begin
              next_q.sel_ep = cb[4:0];
              next_q.state = UPE_ST_EP;
            end else if (in_ep_range(cb, `UPE_CODE_SEL_EP)) begin
              next_q.sel_ep = cb[4:0];
              next_q.state = UPE_ST_RD;
            end else if (cb == `UPE_CODE_CLR_BUF) begin
              next_q.clr_buf = 1'b1;
              next_q.state = UPE_ST_RD;
            end else if (cb == `UPE_CODE_VAL_BUF) begin
              next_q.valid_buf = 1'b1;
              next_q.state = UPE_ST_IDLE;
            end else if (cb == `UPE_CODE_RD_FRAME) begin
              next_q.state = UPE_ST_RD;
            end else begin
              next_q.state = UPE_ST_WR;
            end
          end
        end
        `UPE_PH_WR: begin
          if (q.state == UPE_ST_WR || q.state == UPE_ST_EP) begin
            next_q.taken = 1'b1;
            next_q.state = UPE_ST_IDLE;
            if (q.state == UPE_ST_EP) begin
              next_q.ep_status_wr = 1'b1;
              next_q.ep_status_data = cb;
            end else begin
              case (q.code)
                `UPE_CODE_SET_ADDR: begin
                  addr_wr = 1'b1;
                end
                `UPE_CODE_CONFIG: begin
                  next_q.configured = cb[`UPE_CONF_BIT];
                end
                `UPE_CODE_SET_MODE: begin
                  next_q.mode = cb[6:0];
                end
                default: begin
                  next_q.state = UPE_ST_IDLE;
                end
              endcase
            end
          end
        end
        `UPE_PH_RD: begin
          if ((q.state == UPE_ST_RD || q.state == UPE_ST_EP) && cb == q.code) begin
            next_q.taken = 1'b1;
            next_q.ready = 1'b1;
            next_q.state = UPE_ST_IDLE;
            if (q.code == `UPE_CODE_RD_FRAME) begin
              if (!q.frame_hi) begin
                next_q.cmd_data = frame_num[7:0];
                next_q.frame_hi = 1'b1;
                next_q.state = UPE_ST_RD;
              end else begin
                next_q.cmd_data = {5'h00, frame_num[10:8]};
                next_q.frame_hi = 1'b0;
              end
            end else if (q.code == `UPE_CODE_CLR_BUF) begin
              next_q.cmd_data = i_clr_buf_status;
            end else begin
              next_q.cmd_data = i_ep_status;
              next_q.ep_irq_clr = (q.state == UPE_ST_EP);
            end
          end
        end
        default: begin
          next_q.state = q.state;
        end
      endcase
    end
    if (i_bus_reset) begin
      next_q.configured = 1'b0;
    end
    for (int i = 0; i < 32; i++) begin
      next_q.respond[i] = i_ep_enabled[i] &
                          (next_q.configured | ctrl_ep_mask[i]);
    end
    next_q.respond[0] = 1'b1;
    next_q.respond[1] = 1'b1;
    next_q.needclk = next_q.mode[`UPE_MODE_KEEP_CLK] | i_needclk_req;
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
      q.state <= UPE_ST_IDLE;
      q.mode <= `UPE_MODE_RESET;
      q.respond <= `UPE_CTRL_EP_MASK;
    end else begin
      q <= next_q;
    end
  end

  assign o_cmd_data = q.cmd_data;
  assign o_cmd_word_taken_flag = q.taken;
  assign o_cmd_result_ready_flag = q.ready;
  assign o_configured_flag = q.configured;
  assign o_ep_respond = q.respond;
  assign o_nak_irq_bulk_out = q.mode[`UPE_MODE_NAK_BO];
  assign o_nak_irq_bulk_in = q.mode[`UPE_MODE_NAK_BI];
  assign o_nak_irq_intr_out = q.mode[`UPE_MODE_NAK_IO];
  assign o_nak_irq_intr_in = q.mode[`UPE_MODE_NAK_II];
  assign o_nak_irq_ctrl_out = q.mode[`UPE_MODE_NAK_CO];
  assign o_nak_irq_ctrl_in = q.mode[`UPE_MODE_NAK_CI];
  assign o_keep_clock_running = q.mode[`UPE_MODE_KEEP_CLK];
  assign o_usb_needclk = q.needclk;
  assign o_sel_ep = q.sel_ep;
  assign o_ep_irq_clr = q.ep_irq_clr;
  assign o_ep_status_wr = q.ep_status_wr;
  assign o_ep_status_data = q.ep_status_data;
  assign o_clr_buf = q.clr_buf;
  assign o_valid_buf = q.valid_buf;
  assign o_frame_number = frame_num;
endmodule
`default_nettype wire

// >>> design/upe_frame.sv
`timescale 1ns/1ps
`default_nettype none
module upe_frame (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sof_valid,
  input wire logic [10:0] i_sof_frame,
  output logic [10:0] o_frame_number
);
  import upe_pkg::*;
  upe_frame_s q;
  upe_frame_s next_q;

  // Any received start-of-frame is kept, CRC good or not
  always_comb begin
    next_q = q;
    if (i_sof_valid) begin
      next_q.frame = i_sof_frame;
    end
  end

  // Missing start-of-frame leaves the last value standing
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign o_frame_number = q.frame;
endmodule
`default_nettype wire

// >>> design/upe_pkg.sv
package upe_pkg;
  typedef enum logic [2:0] {
    UPE_ST_IDLE = 3'b000,
    UPE_ST_WR = 3'b001,
    UPE_ST_RD = 3'b010,
    UPE_ST_EP = 3'b011
  } upe_state_e;

  typedef struct packed {
    upe_state_e state;
    logic [7:0] code;
    logic [4:0] sel_ep;
    logic frame_hi;
    logic [7:0] cmd_data;
    logic taken;
    logic ready;
    logic configured;
    logic [6:0] mode;
    logic needclk;
    logic ep_irq_clr;
    logic ep_status_wr;
    logic [7:0] ep_status_data;
    logic clr_buf;
    logic valid_buf;
    logic [31:0] respond;
  } upe_cmd_s;

  typedef struct packed {
    logic [6:0] addr;
    logic enable;
    logic [6:0] pend_addr;
    logic pend_en;
    logic pend_valid;
    logic back2back;
  } upe_addr_s;

  typedef struct packed {
    logic [10:0] frame;
  } upe_frame_s;
endpackage

// >>> design/upe_regs.svh
`ifndef UPE_REGS_SVH
`define UPE_REGS_SVH

// Phase byte of a command code word (bits 15:8)
`define UPE_PH_CMD 8'h05
`define UPE_PH_WR 8'h01
`define UPE_PH_RD 8'h02

// Command code byte (bits 23:16)
`define UPE_CODE_SET_ADDR 8'hD0
`define UPE_CODE_CONFIG 8'hD8
`define UPE_CODE_SET_MODE 8'hF3
`define UPE_CODE_RD_FRAME 8'hF5
`define UPE_CODE_CLR_BUF 8'hF2
`define UPE_CODE_VAL_BUF 8'hFA
`define UPE_CODE_SEL_EP 8'h00
`define UPE_CODE_SEL_CLR 8'h40
`define UPE_CODE_EP_SPAN 8'h20

// Function address and enable byte
`define UPE_ADDR_EN_BIT 7
`define UPE_ADDR_RESET 7'h00
// Configure byte
`define UPE_CONF_BIT 0
// Mode byte
`define UPE_MODE_NAK_BO 6
`define UPE_MODE_NAK_BI 5
`define UPE_MODE_NAK_IO 4
`define UPE_MODE_NAK_II 3
`define UPE_MODE_NAK_CO 2
`define UPE_MODE_NAK_CI 1
`define UPE_MODE_KEEP_CLK 0
`define UPE_MODE_RESET 7'h00

// Flag clear mask bits
`define UPE_FLAG_TAKEN_BIT 4
`define UPE_FLAG_READY_BIT 5

// Physical endpoints of the control pipe
`define UPE_CTRL_EP_MASK 32'h0000_0003

`endif

// >>> test/test_usb_device_protocol_engine_cmds.sv
`timescale 1ns/1ps
`default_nettype none
module test_usb_device_protocol_engine_cmds;
  logic i_clk = 1'b0, i_rst_n = 1'b0, i_cmd_wr = 1'b0, i_needclk_req = 1'b0;
  logic i_bus_reset, i_status_done, i_sof_valid;
  logic [10:0] i_sof_frame, o_frame_number;
  logic [31:0] i_cmd_code = 32'h0, i_ep_enabled = 32'hFFFF_FFFC, o_ep_respond;
  logic [7:0] i_flag_clr = 8'h0, i_ep_status = 8'h3C, i_clr_buf_status = 8'hC3;
  logic [7:0] o_cmd_data, o_ep_status_data;
  logic [6:0] o_function_address;
  logic [4:0] o_sel_ep;
  logic o_cmd_word_taken_flag, o_cmd_result_ready_flag, o_function_enable;
  logic o_configured_flag, o_keep_clock_running, o_usb_needclk;
  logic o_nak_irq_bulk_out, o_nak_irq_bulk_in, o_nak_irq_intr_out;
  logic o_nak_irq_intr_in, o_nak_irq_ctrl_out, o_nak_irq_ctrl_in;
  logic o_ep_irq_clr, o_ep_status_wr, o_clr_buf, o_valid_buf;
  int error_cnt = 0;
  int checks_done = 0;
  always #5 i_clk = ~i_clk;
  upe_cmd u_dut (.*);
  upe_host_model u_host (.i_clk(i_clk), .o_sof_valid(i_sof_valid),
    .o_sof_frame(i_sof_frame), .o_bus_reset(i_bus_reset), .o_status_done(i_status_done));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Clears both flags, writes one word, returns in the answer cycle
  task automatic word(input logic [31:0] w, input logic taken);
    @(negedge i_clk);
    i_flag_clr = 8'h30;
    @(negedge i_clk);
    i_flag_clr = 8'h00;
    i_cmd_wr = 1'b1;
    i_cmd_code = w;
    @(negedge i_clk);
    i_cmd_wr = 1'b0;
    chk(o_cmd_word_taken_flag, taken);
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    word({8'h00, c, 8'h02, 8'h00}, 1'b1);
    chk(o_cmd_result_ready_flag, 1'b1);
    chk(o_cmd_data, exp);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] b);
    word({8'h00, c, 8'h05, 8'h00}, 1'b1);
    word({8'h00, b, 8'h01, 8'h00}, 1'b1);
  endtask
  task automatic t_mode;
    for (int b = 0; b < 7; b++) begin
      wr(8'hF3, 8'h01 << b);
      chk({o_nak_irq_bulk_out, o_nak_irq_bulk_in, o_nak_irq_intr_out,
        o_nak_irq_intr_in, o_nak_irq_ctrl_out, o_nak_irq_ctrl_in,
        o_keep_clock_running}, 32'h1 << b);
      @(negedge i_clk);
      chk(o_usb_needclk, b == 0);
    end
    i_needclk_req = 1'b1;
    repeat (2) @(negedge i_clk);
    chk(o_usb_needclk, 1'b1);
    wr(8'hF3, 8'h00);
  endtask
  task automatic t_endpoint;
    word(32'h005F0500, 1'b1);
    chk(o_sel_ep, 5'h1F);
    word(32'h00450500, 1'b1);
    chk(o_sel_ep, 5'h05);
    word(32'h00460200, 1'b0);
    chk(o_cmd_result_ready_flag, 1'b0);
    rd(8'h45, 8'h3C);
    chk(o_ep_irq_clr, 1'b1);
    wr(8'h45, 8'hA5);
    chk({o_ep_status_wr, o_ep_status_data}, 9'h1A5);
    word(32'h00F20500, 1'b1);
    chk(o_clr_buf, 1'b1);
    rd(8'hF2, 8'hC3);
    word(32'h00FA0500, 1'b1);
    chk(o_valid_buf, 1'b1);
    word(32'h00FA0200, 1'b0);
  endtask
  task automatic t_config;
    wr(8'hD8, 8'h01);
    @(negedge i_clk);
    chk(o_configured_flag, 1'b1);
    chk(o_ep_respond, 32'hFFFF_FFFF);
    i_ep_enabled = 32'h0000_0F00;
    @(negedge i_clk);
    chk(o_ep_respond, 32'h0000_0F03);
    word(32'h00FD0500, 1'b0);
    word(32'h00D80100, 1'b0);
    chk(o_configured_flag, 1'b1);
  endtask
  task automatic t_address;
    wr(8'hD0, 8'h85);
    chk({o_function_enable, o_function_address}, 8'h00);
    u_host.status_stage();
    chk({o_function_enable, o_function_address}, 8'h85);
    wr(8'hD0, 8'h9A);
    chk({o_function_enable, o_function_address}, 8'h85);
    wr(8'hD0, 8'h9A);
    @(negedge i_clk);
    chk({o_function_enable, o_function_address}, 8'h9A);
    u_host.bus_reset();
    chk({o_function_enable, o_function_address}, 8'h80);
    chk(o_ep_respond, 32'h3);
  endtask
  task automatic t_frame;
    u_host.sof(11'h5A3);
    chk(o_frame_number, 11'h5A3);
    word(32'h00F50500, 1'b1);
    rd(8'hF5, 8'hA3);
    rd(8'hF5, 8'h05);
    repeat (3) @(negedge i_clk);
    word(32'h00F50500, 1'b1);
    rd(8'hF5, 8'hA3);
    u_host.sof(11'h7FE);
    word(32'h00F50500, 1'b1);
    rd(8'hF5, 8'hFE);
    rd(8'hF5, 8'h07);
  endtask
  task automatic tally_and_finish;
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    repeat (5) @(negedge i_clk);
    i_rst_n = 1'b1;
    chk(o_function_enable, 1'b0);
    chk(o_ep_respond, 32'h3);
    t_mode();
    t_endpoint();
    t_config();
    t_address();
    t_frame();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// >>> test/upe_cmd_sva.sv
`timescale 1ns/1ps
`default_nettype none
module upe_cmd_sva (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_wr,
  input wire logic [31:0] i_cmd_code,
  input wire logic i_bus_reset,
  input wire logic i_sof_valid,
  input wire logic [10:0] i_sof_frame,
  input wire logic i_needclk_req,
  input wire logic [31:0] i_ep_enabled,
  input wire logic o_cmd_word_taken_flag,
  input wire logic [6:0] o_function_address,
  input wire logic o_function_enable,
  input wire logic o_configured_flag,
  input wire logic [31:0] o_ep_respond,
  input wire logic o_keep_clock_running,
  input wire logic o_usb_needclk,
  input wire logic [10:0] o_frame_number
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  a_word_taken: assert property (i_cmd_wr && i_cmd_code == 32'h00F30500
    |=> o_cmd_word_taken_flag) else $error("mode word not taken");
  a_unknown_quiet: assert property (i_cmd_wr && i_cmd_code == 32'h00FD0500
    && !o_cmd_word_taken_flag |=> !o_cmd_word_taken_flag) else $error("unknown word taken");
  a_bus_reset_state: assert property (i_bus_reset |=> o_function_address == 7'h00
    && o_function_enable && !o_configured_flag) else $error("bus reset state wrong");
  a_ctrl_ep_on: assert property (o_ep_respond[1:0] == 2'b11)
    else $error("control endpoint silent");
  a_unconf_quiet: assert property (!$past(o_configured_flag) && !o_configured_flag
    |-> o_ep_respond[31:2] == 30'h0) else $error("endpoint answers unconfigured");
  a_conf_follow: assert property ($past(o_configured_flag) && o_configured_flag
    |-> o_ep_respond[31:2] == $past(i_ep_enabled[31:2])) else $error("respond wrong");
  a_clk_request: assert property ($past(i_rst_n)
    |-> o_usb_needclk == (o_keep_clock_running | $past(i_needclk_req)))
    else $error("clock request wrong");
  a_frame_store: assert property (i_sof_valid
    |=> o_frame_number == $past(i_sof_frame)) else $error("frame not stored");
  a_frame_hold: assert property (!i_sof_valid |=> $stable(o_frame_number))
    else $error("frame changed without token");
endmodule
bind upe_cmd upe_cmd_sva u_sva (.*);
`default_nettype wire

// >>> test/upe_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module upe_host_model (
  input wire logic i_clk,
  output logic o_sof_valid,
  output logic [10:0] o_sof_frame,
  output logic o_bus_reset,
  output logic o_status_done
);
  logic [10:0] frame_q = 11'h0;
  initial begin
    o_sof_valid = 1'b0;
    o_bus_reset = 1'b0;
    o_status_done = 1'b0;
  end
  // Stale frame field shown inverted between tokens
  assign o_sof_frame = o_sof_valid ? frame_q : ~frame_q;
  // Token delivered even with a damaged CRC
  task automatic sof(input logic [10:0] f);
    @(negedge i_clk);
    frame_q = f;
    o_sof_valid = 1'b1;
    @(negedge i_clk);
    o_sof_valid = 1'b0;
  endtask
  task automatic bus_reset;
    @(negedge i_clk);
    o_bus_reset = 1'b1;
    @(negedge i_clk);
    o_bus_reset = 1'b0;
  endtask
  task automatic status_stage;
    @(negedge i_clk);
    o_status_done = 1'b1;
    @(negedge i_clk);
    o_status_done = 1'b0;
  endtask
endmodule
`default_nettype wire
